/* pkg/pc_seq_consts.svh */
// named constants for the program counter sequencer
`ifndef PC_SEQ_CONSTS_SVH
`define PC_SEQ_CONSTS_SVH

// datapath widths
`define PC_W 15
`define LOW_W 8
`define LATCH_W 7
`define OPERAND_W 11
`define WORK_W 8
`define PC_RESET 15'h0000
`define LATCH_RESET 7'h00
`define PC_STEP 15'h0001

// absolute call: operand fills the low bits, latch bits fill the page
`define CALL_ABS_W 11
`define CALL_PAGE_LSB 3
`define CALL_PAGE_MSB 6

// register bus
`define AXI_DATA_W 32
`define AXI_ADDR_W 32
`define DEC_MSB 3
`define OFS_PC_LOW 4'h0
`define OFS_PC_LATCH 4'h4
`define OFS_STATUS 4'h8
`define OFS_CONTROL 4'hC
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CTRL_HOLD_BIT 0
`define STATUS_OP_LSB 16
`define STATUS_OP_MSB 18

`endif

/* pkg/pc_seq_pkg.sv */
// types shared by the program counter sequencer modules
`include "pc_seq_consts.svh"

package pc_seq_pkg;

	typedef enum logic [2:0] {
		OP_FETCH,
		OP_WRITE_LOW,
		OP_CALL_ABS,
		OP_CALL_WORKING,
		OP_BRANCH_WORKING,
		OP_BRANCH_SIGNED,
		OP_RETURN
	} pc_op_t;

	typedef struct packed {
		logic valid;
		pc_op_t op;
		logic [`OPERAND_W-1:0] operand;
		logic [`WORK_W-1:0] working;
		logic [`LOW_W-1:0] result;
		logic [`PC_W-1:0] ret_addr;
	} pc_cmd_t;

	typedef struct packed {
		logic valid;
		logic [`DEC_MSB:0] addr;
		logic [`AXI_DATA_W-1:0] data;
		logic [3:0] strb;
	} wr_req_t;

	typedef struct packed {
		logic aw_held;
		logic w_held;
		logic [`DEC_MSB:0] addr;
		logic [`AXI_DATA_W-1:0] data;
		logic [3:0] strb;
		logic awready;
		logic wready;
	} wr_cap_state_t;

	typedef struct packed {
		logic [`PC_W-1:0] pc;
		logic [`LATCH_W-1:0] latch;
		logic hold;
		pc_op_t last_op;
		logic push_valid;
		logic [`PC_W-1:0] push_addr;
		logic pop_valid;
		logic arready;
		logic rvalid;
		logic [`AXI_DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic bvalid;
		logic [1:0] bresp;
	} seq_state_t;

endpackage : pc_seq_pkg

/* rtl/pc_target_calc.sv */
// next program counter value for each instruction kind
`timescale 1ns/1ps
`default_nettype none

module pc_target_calc
	import pc_seq_pkg::*;
(
	// current state
	input wire logic [`PC_W-1:0] pc_in,
	input wire logic [`LATCH_W-1:0] latch_in,
	// instruction
	input wire pc_cmd_t cmd_in,
	// result
	output logic [`PC_W-1:0] next_pc_out,
	output logic push_out,
	output logic pop_out
);

	logic [`PC_W-1:0] pc_plus_one;
	logic [`PC_W-1:0] signed_ofs;

	// branches start from the already advanced address, full-width add
	assign pc_plus_one = pc_in + `PC_STEP;
	assign signed_ofs = {{(`PC_W-`OPERAND_W){cmd_in.operand[`OPERAND_W-1]}}, cmd_in.operand};

	always_comb begin
		next_pc_out = pc_in;
		push_out = 1'b0;
		pop_out = 1'b0;
		unique case (cmd_in.op)
			OP_FETCH: begin
				next_pc_out = pc_plus_one;
			end
			OP_WRITE_LOW: begin
				// result is already the 8-bit sum, so no carry reaches the page
				next_pc_out = {latch_in, cmd_in.result};
			end
			OP_CALL_ABS: begin
				next_pc_out = {latch_in[`CALL_PAGE_MSB:`CALL_PAGE_LSB], cmd_in.operand[`CALL_ABS_W-1:0]};
				push_out = 1'b1;
			end
			OP_CALL_WORKING: begin
				next_pc_out = {latch_in, cmd_in.working};
				push_out = 1'b1;
			end
			OP_BRANCH_WORKING: begin
				next_pc_out = pc_plus_one + {{(`PC_W-`WORK_W){1'b0}}, cmd_in.working};
			end
			OP_BRANCH_SIGNED: begin
				next_pc_out = pc_plus_one + signed_ofs;
			end
			OP_RETURN: begin
				next_pc_out = cmd_in.ret_addr;
				pop_out = 1'b1;
			end
			default: begin
				next_pc_out = pc_in;
			end
		endcase
	end

endmodule : pc_target_calc

`default_nettype wire

/* rtl/axil_write_capture.sv */
// takes AXI4-Lite write address and data in either order and holds them
`timescale 1ns/1ps
`default_nettype none

module axil_write_capture
	import pc_seq_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// AXI4-Lite write address and data
	input wire logic awvalid_in,
	input wire logic [`DEC_MSB:0] awaddr_in,
	input wire logic wvalid_in,
	input wire logic [`AXI_DATA_W-1:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	output logic awready_out,
	output logic wready_out,
	// paired request towards the register file
	output wr_req_t req_out,
	input wire logic consume_in
);

	wr_cap_state_t s_q;
	wr_cap_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (awvalid_in && s_q.awready) begin
			s_d.aw_held = 1'b1;
			s_d.addr = awaddr_in;
		end
		if (wvalid_in && s_q.wready) begin
			s_d.w_held = 1'b1;
			s_d.data = wdata_in;
			s_d.strb = wstrb_in;
		end
		if (consume_in) begin
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
		end
		// ready only while the slot is empty; holds off a second write
		s_d.awready = !s_d.aw_held;
		s_d.wready = !s_d.w_held;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign awready_out = s_q.awready;
	assign wready_out = s_q.wready;
	assign req_out = '{valid: s_q.aw_held && s_q.w_held, addr: s_q.addr, data: s_q.data, strb: s_q.strb};

endmodule : axil_write_capture

`default_nettype wire

/* rtl/pc_sequencer.sv */
// program counter sequencer with low-byte register, high latch and AXI4-Lite access
//
// Functional notes
// - 15-bit program counter; low eight bits readable and writable as a register.
// - upper seven bits never accessed directly; set from latch, operand, return address or by carry.
// - any reset clears the whole program counter.
// - writing the low-byte register also copies the high latch into bits 14..8.
// - computed jump adds into the low byte only; no carry into upper bits.
// - absolute call loads bits 10..0 from operand, 14..11 from latch 6..3.
// - call via working loads low byte from working, upper bits from latch.
// - both branches add to the incremented counter across the full width.
// - branch by working loads address plus one plus unsigned working value.
// - signed branch loads address plus one plus sign-extended operand.
// - stack push or pop leaves the high latch unchanged.
`timescale 1ns/1ps
`default_nettype none

module pc_sequencer
	import pc_seq_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic SYS_RST_IN,
	// instruction command port
	input wire logic CMD_VALID_IN,
	input wire logic [2:0] CMD_OP_IN,
	input wire logic [`OPERAND_W-1:0] CMD_OPERAND_IN,
	input wire logic [`WORK_W-1:0] CMD_WORKING_IN,
	input wire logic [`LOW_W-1:0] CMD_RESULT_IN,
	input wire logic [`PC_W-1:0] CMD_RET_ADDR_IN,
	// program counter and stack side
	output logic [`PC_W-1:0] PC_OUT,
	output logic [`LATCH_W-1:0] LATCH_OUT,
	output logic PUSH_VALID_OUT,
	output logic [`PC_W-1:0] PUSH_ADDR_OUT,
	output logic POP_VALID_OUT,
	// AXI4-Lite write address
	input wire logic S_AXI_AWVALID_IN,
	input wire logic [`AXI_ADDR_W-1:0] S_AXI_AWADDR_IN,
	input wire logic [2:0] S_AXI_AWPROT_IN,
	output logic S_AXI_AWREADY_OUT,
	// AXI4-Lite write data
	input wire logic S_AXI_WVALID_IN,
	input wire logic [`AXI_DATA_W-1:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	output logic S_AXI_WREADY_OUT,
	// AXI4-Lite write response
	output logic S_AXI_BVALID_OUT,
	output logic [1:0] S_AXI_BRESP_OUT,
	input wire logic S_AXI_BREADY_IN,
	// AXI4-Lite read address
	input wire logic S_AXI_ARVALID_IN,
	input wire logic [`AXI_ADDR_W-1:0] S_AXI_ARADDR_IN,
	input wire logic [2:0] S_AXI_ARPROT_IN,
	output logic S_AXI_ARREADY_OUT,
	// AXI4-Lite read data
	output logic S_AXI_RVALID_OUT,
	output logic [`AXI_DATA_W-1:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	input wire logic S_AXI_RREADY_IN
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	seq_state_t s_q;
	seq_state_t s_d;
	pc_cmd_t cmd;
	wr_req_t wr_req;
	logic [`PC_W-1:0] calc_pc;
	logic calc_push;
	logic calc_pop;
	logic cmd_take;
	logic wr_apply;
	logic wr_low_hit;
	logic wr_latch_hit;
	logic wr_ctrl_hit;
	logic wr_mapped;
	logic [`DEC_MSB:0] rd_addr;
	logic rd_mapped;
	logic [`AXI_DATA_W-1:0] rd_word;
	logic unused_bits;

	// protection and the upper address bits carry no meaning here
	assign unused_bits = ^{S_AXI_AWPROT_IN, S_AXI_ARPROT_IN,
		S_AXI_AWADDR_IN[`AXI_ADDR_W-1:`DEC_MSB+1], S_AXI_ARADDR_IN[`AXI_ADDR_W-1:`DEC_MSB+1]};

	////////////////////////////////////////////////////////////////////////////////
	// instruction command decode

	always_comb begin
		cmd.valid = CMD_VALID_IN;
		cmd.op = pc_op_t'(CMD_OP_IN);
		cmd.operand = CMD_OPERAND_IN;
		cmd.working = CMD_WORKING_IN;
		cmd.result = CMD_RESULT_IN;
		cmd.ret_addr = CMD_RET_ADDR_IN;
	end

	// a held sequencer ignores plain fetches but still obeys flow changes
	assign cmd_take = cmd.valid && !(s_q.hold && (cmd.op == OP_FETCH));

	pc_target_calc u_pc_target_calc (
		.pc_in(s_q.pc),
		.latch_in(s_q.latch),
		.cmd_in(cmd),
		.next_pc_out(calc_pc),
		.push_out(calc_push),
		.pop_out(calc_pop)
	);

	////////////////////////////////////////////////////////////////////////////////
	// write channel capture

	axil_write_capture u_axil_write_capture (
		.clk_in(SYS_CLK_IN),
		.rst_in(SYS_RST_IN),
		.awvalid_in(S_AXI_AWVALID_IN),
		.awaddr_in(S_AXI_AWADDR_IN[`DEC_MSB:0]),
		.wvalid_in(S_AXI_WVALID_IN),
		.wdata_in(S_AXI_WDATA_IN),
		.wstrb_in(S_AXI_WSTRB_IN),
		.awready_out(S_AXI_AWREADY_OUT),
		.wready_out(S_AXI_WREADY_OUT),
		.req_out(wr_req),
		.consume_in(wr_apply)
	);

	// a bus write waits for a cycle free of instructions, so the core never
	// sees its counter change under two writers at once
	assign wr_apply = wr_req.valid && !CMD_VALID_IN && !s_q.bvalid;
	assign wr_low_hit = (wr_req.addr == `OFS_PC_LOW) && wr_req.strb[0];
	assign wr_latch_hit = (wr_req.addr == `OFS_PC_LATCH) && wr_req.strb[0];
	assign wr_ctrl_hit = (wr_req.addr == `OFS_CONTROL) && wr_req.strb[0];
	assign wr_mapped = (wr_req.addr == `OFS_PC_LOW) || (wr_req.addr == `OFS_PC_LATCH)
		|| (wr_req.addr == `OFS_CONTROL) || (wr_req.addr == `OFS_STATUS);

	////////////////////////////////////////////////////////////////////////////////
	// read decode

	assign rd_addr = S_AXI_ARADDR_IN[`DEC_MSB:0];

	always_comb begin
		rd_word = '0;
		rd_mapped = 1'b1;
		unique case (rd_addr)
			`OFS_PC_LOW: begin
				rd_word[`LOW_W-1:0] = s_q.pc[`LOW_W-1:0];
			end
			`OFS_PC_LATCH: begin
				// the latch, not the live upper counter bits
				rd_word[`LATCH_W-1:0] = s_q.latch;
			end
			`OFS_STATUS: begin
				// low byte only; the upper counter bits stay hidden from software
				rd_word[`LOW_W-1:0] = s_q.pc[`LOW_W-1:0];
				rd_word[`STATUS_OP_MSB:`STATUS_OP_LSB] = s_q.last_op;
			end
			`OFS_CONTROL: begin
				rd_word[`CTRL_HOLD_BIT] = s_q.hold;
			end
			default: begin
				rd_mapped = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;
		s_d.push_valid = 1'b0;
		s_d.pop_valid = 1'b0;

		// instruction flow
		if (cmd_take) begin
			s_d.pc = calc_pc;
			s_d.last_op = cmd.op;
			if (calc_push) begin
				// return address is the instruction after the call
				s_d.push_valid = 1'b1;
				s_d.push_addr = s_q.pc + `PC_STEP;
			end
			// stack traffic never touches the latch
			s_d.pop_valid = calc_pop;
		end

		// software writes
		if (wr_apply) begin
			if (wr_low_hit) begin
				s_d.pc = {s_q.latch, wr_req.data[`LOW_W-1:0]};
				s_d.last_op = OP_WRITE_LOW;
			end
			if (wr_latch_hit) begin
				s_d.latch = wr_req.data[`LATCH_W-1:0];
			end
			if (wr_ctrl_hit) begin
				s_d.hold = wr_req.data[`CTRL_HOLD_BIT];
			end
			s_d.bvalid = 1'b1;
			s_d.bresp = wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_q.bvalid && S_AXI_BREADY_IN) begin
			s_d.bvalid = 1'b0;
		end

		// reads: one outstanding, data registered
		if (S_AXI_ARVALID_IN && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_word;
			s_d.rresp = rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_q.rvalid && S_AXI_RREADY_IN) begin
			s_d.rvalid = 1'b0;
		end
		s_d.arready = !s_d.rvalid;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			s_q <= '0;
			s_q.pc <= `PC_RESET;
			s_q.latch <= `LATCH_RESET;
			s_q.last_op <= OP_FETCH;
			s_q.arready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register

	assign PC_OUT = s_q.pc;
	assign LATCH_OUT = s_q.latch;
	assign PUSH_VALID_OUT = s_q.push_valid;
	assign PUSH_ADDR_OUT = s_q.push_addr;
	assign POP_VALID_OUT = s_q.pop_valid;
	assign S_AXI_BVALID_OUT = s_q.bvalid;
	assign S_AXI_BRESP_OUT = s_q.bresp;
	assign S_AXI_ARREADY_OUT = s_q.arready;
	assign S_AXI_RVALID_OUT = s_q.rvalid;
	assign S_AXI_RDATA_OUT = s_q.rdata;
	assign S_AXI_RRESP_OUT = s_q.rresp;

endmodule : pc_sequencer

`default_nettype wire

/* verification/pc_sequencer_sva.sv */
// port-level assertions for the program counter sequencer
`timescale 1ns/1ps
`default_nettype none

module pc_sequencer_sva
	import pc_seq_pkg::*;
(
	// clock, reset and command
	input wire logic SYS_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic CMD_VALID_IN,
	input wire logic [2:0] CMD_OP_IN,
	input wire logic [`OPERAND_W-1:0] CMD_OPERAND_IN,
	input wire logic [`WORK_W-1:0] CMD_WORKING_IN,
	input wire logic [`LOW_W-1:0] CMD_RESULT_IN,
	input wire logic [`PC_W-1:0] CMD_RET_ADDR_IN,
	// counter and stack side
	input wire logic [`PC_W-1:0] PC_OUT,
	input wire logic [`LATCH_W-1:0] LATCH_OUT,
	input wire logic PUSH_VALID_OUT,
	input wire logic [`PC_W-1:0] PUSH_ADDR_OUT,
	input wire logic POP_VALID_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	////////////////////////////////////////////////////////////////
	// reset must be seen while it is held, so no disable here
	AST_RST_CLEAR: assert property (disable iff (1'h0) SYS_RST_IN |-> PC_OUT == 15'h0000)
		else $error("counter not cleared during reset");
	AST_WRITE_LOW: assert property (CMD_VALID_IN && CMD_OP_IN == 3'h1 |=>
		PC_OUT == {$past(LATCH_OUT), $past(CMD_RESULT_IN)})
		else $error("low byte write gave wrong counter");
	AST_CALL_ABS: assert property (CMD_VALID_IN && CMD_OP_IN == 3'h2 |=>
		PC_OUT == {$past(LATCH_OUT[6:3]), $past(CMD_OPERAND_IN)})
		else $error("absolute call gave wrong counter");
	AST_CALL_WORK: assert property (CMD_VALID_IN && CMD_OP_IN == 3'h3 |=>
		PC_OUT == {$past(LATCH_OUT), $past(CMD_WORKING_IN)})
		else $error("call via working gave wrong counter");
	AST_BR_WORK: assert property (CMD_VALID_IN && CMD_OP_IN == 3'h4 |=>
		PC_OUT == $past(PC_OUT) + 15'h0001 + {7'h00, $past(CMD_WORKING_IN)})
		else $error("branch by working gave wrong counter");
	AST_BR_SIGNED: assert property (CMD_VALID_IN && CMD_OP_IN == 3'h5 |=>
		PC_OUT == $past(PC_OUT) + 15'h0001 + {{4{$past(CMD_OPERAND_IN[10])}}, $past(CMD_OPERAND_IN)})
		else $error("signed branch gave wrong counter");
	AST_PUSH: assert property (CMD_VALID_IN && (CMD_OP_IN == 3'h2 || CMD_OP_IN == 3'h3) |=>
		PUSH_VALID_OUT && PUSH_ADDR_OUT == $past(PC_OUT) + 15'h0001 && $stable(LATCH_OUT))
		else $error("call push wrong or latch moved");
	AST_POP: assert property (CMD_VALID_IN && CMD_OP_IN == 3'h6 |=>
		POP_VALID_OUT && PC_OUT == $past(CMD_RET_ADDR_IN) && $stable(LATCH_OUT))
		else $error("return pop wrong or latch moved");
	AST_ILLEGAL: assert property (CMD_VALID_IN && CMD_OP_IN == 3'h7 |=> $stable(PC_OUT))
		else $error("illegal op moved the counter");
	AST_NO_PULSE: assert property (!CMD_VALID_IN |=> !PUSH_VALID_OUT && !POP_VALID_OUT)
		else $error("stack pulse without command");
endmodule : pc_sequencer_sva

`default_nettype wire

/* verification/program_counter_loader_tb.sv */
// self-checking bench for the program counter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pc_seq_consts.svh"

module program_counter_loader_tb;
	logic clk, rst, cv, pv, pp, awv, awr, wv, wr, bv, brdy, arv, arr, rv, rrdy;
	logic [2:0] cop;
	logic [10:0] copd;
	logic [7:0] cw, cr;
	logic [14:0] cra, pc, pa;
	logic [6:0] lat;
	logic [3:0] ws;
	logic [31:0] awa, ara, wd, rd, v;
	logic [1:0] bresp, rresp, x;
	int err_count = 0;
	int compares = 0;

	pc_sequencer u_pc_sequencer (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .CMD_VALID_IN(cv), .CMD_OP_IN(cop),
		.CMD_OPERAND_IN(copd), .CMD_WORKING_IN(cw), .CMD_RESULT_IN(cr), .CMD_RET_ADDR_IN(cra), .PC_OUT(pc),
		.LATCH_OUT(lat), .PUSH_VALID_OUT(pv), .PUSH_ADDR_OUT(pa), .POP_VALID_OUT(pp), .S_AXI_AWVALID_IN(awv),
		.S_AXI_AWADDR_IN(awa), .S_AXI_AWPROT_IN(3'h0), .S_AXI_AWREADY_OUT(awr), .S_AXI_WVALID_IN(wv),
		.S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WREADY_OUT(wr), .S_AXI_BVALID_OUT(bv),
		.S_AXI_BRESP_OUT(bresp), .S_AXI_BREADY_IN(brdy), .S_AXI_ARVALID_IN(arv), .S_AXI_ARADDR_IN(ara),
		.S_AXI_ARPROT_IN(3'h0), .S_AXI_ARREADY_OUT(arr), .S_AXI_RVALID_OUT(rv), .S_AXI_RDATA_OUT(rd),
		.S_AXI_RRESP_OUT(rresp), .S_AXI_RREADY_IN(rrdy));

	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("Error at %0t: seen %0h expected %0h", $time, s, e);
		end
	endtask : chk

	task finish_test;
		if (err_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	task lim(input int n);
		if (n >= 40) begin
			err_count++;
			finish_test;
		end
	endtask : lim

	// one instruction, then an idle cycle so the result can be looked at
	task cmd(input logic [2:0] o, input logic [10:0] a, input logic [7:0] w, input logic [7:0] r,
		input logic [14:0] ra);
		@(posedge clk);
		cv <= 1'h1;
		cop <= o;
		copd <= a;
		cw <= w;
		cr <= r;
		cra <= ra;
		@(posedge clk);
		cv <= 1'h0;
		#1;
	endtask : cmd

	task axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge clk);
		awa <= {28'h0, a};
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		brdy <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (awr) awv <= 1'h0;
			if (wr) wv <= 1'h0;
		end while (!bv && n < 40);
		brdy <= 1'h0;
		lim(n);
		chk(bresp, e);
	endtask : axw

	task axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] e);
		int n;
		n = 0;
		@(posedge clk);
		ara <= {28'h0, a};
		arv <= 1'h1;
		rrdy <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (arr) arv <= 1'h0;
		end while (!rv && n < 40);
		rrdy <= 1'h0;
		d = rd;
		e = rresp;
		lim(n);
	endtask : axr

	task setpc(input logic [14:0] p);
		axw(`OFS_PC_LATCH, {25'h0, p[14:8]}, `RESP_OKAY);
		axw(`OFS_PC_LOW, {24'h0, p[7:0]}, `RESP_OKAY);
		chk(pc, p);
	endtask : setpc

	////////////////////////////////////////////////////////////////
	task t_regs;
		chk(pc, 15'h0000);
		axw(`OFS_PC_LATCH, 32'hFFFFFFFF, `RESP_OKAY);
		axr(`OFS_PC_LATCH, v, x);
		chk(v, 32'h0000007F);
		axw(`OFS_PC_LOW, 32'h000000A5, `RESP_OKAY);
		chk(pc, 15'h7FA5);
		axr(`OFS_PC_LOW, v, x);
		chk(v, 32'h000000A5);
		axr(4'h2, v, x);
		chk(x, `RESP_SLVERR);
		// a write with its low strobe off must leave the latch alone
		ws <= 4'h0;
		axw(`OFS_PC_LATCH, 32'h00000000, `RESP_OKAY);
		ws <= 4'hF;
		axr(`OFS_PC_LATCH, v, x);
		chk(v, 32'h0000007F);
	endtask : t_regs

	// top of the address space wraps to zero; hold refuses fetches
	task t_wrap_hold;
		setpc(15'h7FFF);
		cmd(3'h0, 11'h000, 8'h00, 8'h00, 15'h0000);
		chk(pc, 15'h0000);
		axw(`OFS_CONTROL, 32'h00000001, `RESP_OKAY);
		axr(`OFS_CONTROL, v, x);
		chk(v, 32'h00000001);
		cmd(3'h0, 11'h000, 8'h00, 8'h00, 15'h0000);
		chk(pc, 15'h0000);
		axw(`OFS_CONTROL, 32'h00000000, `RESP_OKAY);
		cmd(3'h7, 11'h000, 8'h00, 8'h00, 15'h0000);
		cmd(3'h0, 11'h000, 8'h00, 8'h00, 15'h0000);
		chk(pc, 15'h0001);
	endtask : t_wrap_hold

	// table offset overflows the low byte: no carry upward
	task t_low_calls;
		setpc(15'h12F0);
		cmd(3'h1, 11'h000, 8'h20, 8'h10, 15'h0000);
		chk(pc, 15'h1210);
		axw(`OFS_PC_LATCH, 32'h00000048, `RESP_OKAY);
		cmd(3'h2, 11'h123, 8'h00, 8'h00, 15'h0000);
		chk(pc, 15'h4923);
		chk({pv, pa}, {1'h1, 15'h1211});
		cmd(3'h3, 11'h000, 8'h5A, 8'h00, 15'h0000);
		chk(pc, 15'h485A);
		cmd(3'h6, 11'h000, 8'h00, 8'h00, 15'h0321);
		chk({pp, pc, lat}, {1'h1, 15'h0321, 7'h48});
		// status shows last op and the low byte, never the upper counter bits
		axr(`OFS_STATUS, v, x);
		chk(v, 32'h00060021);
	endtask : t_low_calls

	task t_branch;
		setpc(15'h00F0);
		cmd(3'h4, 11'h000, 8'h20, 8'h00, 15'h0000);
		chk(pc, 15'h0111);
		cmd(3'h5, 11'h7FE, 8'h00, 8'h00, 15'h0000);
		chk(pc, 15'h0110);
		cmd(3'h5, 11'h3FF, 8'h00, 8'h00, 15'h0000);
		chk(pc, 15'h0510);
	endtask : t_branch

	task t_rst2;
		setpc(15'h1234);
		@(posedge clk);
		rst <= 1'h1;
		@(posedge clk);
		#1;
		chk({pc, lat}, 22'h000000);
		chk({awr, wr, arr, bv, rv}, 32'h00000004);
		@(posedge clk);
		rst <= 1'h0;
		cmd(3'h0, 11'h000, 8'h00, 8'h00, 15'h0000);
		chk(pc, 15'h0001);
	endtask : t_rst2

	initial begin
		{cv, cop, copd, cw, cr, cra} = '0;
		{awv, wv, brdy, arv, rrdy, awa, ara, wd} = '0;
		ws = 4'hF;
		// a clean rising edge, so the asynchronous reset is seen before the first clock
		rst = 1'h0;
		#1;
		rst = 1'h1;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		#1;
		t_regs;
		t_wrap_hold;
		t_low_calls;
		t_branch;
		t_rst2;
		finish_test;
	end
endmodule : program_counter_loader_tb

bind pc_sequencer pc_sequencer_sva u_sva (.SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
	.CMD_VALID_IN(CMD_VALID_IN), .CMD_OP_IN(CMD_OP_IN), .CMD_OPERAND_IN(CMD_OPERAND_IN),
	.CMD_WORKING_IN(CMD_WORKING_IN), .CMD_RESULT_IN(CMD_RESULT_IN), .CMD_RET_ADDR_IN(CMD_RET_ADDR_IN),
	.PC_OUT(PC_OUT), .LATCH_OUT(LATCH_OUT), .PUSH_VALID_OUT(PUSH_VALID_OUT), .PUSH_ADDR_OUT(PUSH_ADDR_OUT),
	.POP_VALID_OUT(POP_VALID_OUT));

`default_nettype wire
